// ===== logic/ivt_defines.vh
// Constants of the interrupt vector and trap unit: register offsets,
// field positions, reset values, trap numbers and trap ranks.
// Included by the top-level design file of the unit; definitions only.
`ifndef IVT_DEFINES_VH
`define IVT_DEFINES_VH

// Register offsets (word addresses on the plain register port)
`define IVT_A_REQ      8'h00
`define IVT_A_EN       8'h04
`define IVT_A_TFR      8'h08
`define IVT_A_STS      8'h09
`define IVT_A_MSK      8'h0a
`define IVT_A_CORE     8'h0b
`define IVT_A_PRIO     8'h40

// Source table: index i carries trap number base + i
`define IVT_NSRC       50
`define IVT_TN_BASE    7'h16

// Hardware trap inputs and their trap numbers
`define IVT_NTRAP      9
`define IVT_TN_NMI     7'h02
`define IVT_TN_STKOF   7'h04
`define IVT_TN_STKUF   7'h06
`define IVT_TN_CLSB    7'h0a
`define IVT_CLSB_MASK  9'h1f8

// Trap ranks; zero means no trap service running
`define IVT_RK_NONE    3'd0
`define IVT_RK_CLSB    3'd1
`define IVT_RK_STKUF   3'd2
`define IVT_RK_STKOF   3'd3
`define IVT_RK_NMI     3'd4

// Level shown for a trap service
`define IVT_LVL_TRAP   4'hf

// Status event bits
`define IVT_EV_FLAG    0
`define IVT_EV_TRAP    1
`define IVT_EV_INT     2
`define IVT_NEV        3

// Reset values
`define IVT_RST_EN     64'h0
`define IVT_RST_PRIO   4'h0
`define IVT_RST_MSK    3'h0

`endif

// ===== logic/ivt_flag.v
// Bank of sticky flags: a set pulse raises a flag, a clear pulse drops it.
// Assumes a reset already synchronised to clk.
`timescale 1ns/1ns
module ivt_flag #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    output wire [W-1:0] flag
);
    reg  [W-1:0] flag_r;
    wire [W-1:0] flag_nxt;

    // Set wins over a clear in the same cycle
    assign flag_nxt = (flag_r & ~clr) | set;
    assign flag     = flag_r;

    // Flag storage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            flag_r <= {W{1'b0}};
        else
            flag_r <= flag_nxt;
    end
endmodule // ivt_flag

// ===== logic/ivt_arb.v
// Picks the pending source of highest priority level; on a tie the
// lowest index wins. Purely combinational.
// Assumes priority fields packed LW bits per source, source 0 lowest.
`timescale 1ns/1ns
module ivt_arb #(
    parameter N  = 50,
    parameter IW = 6,
    parameter LW = 4
) (
    input  wire [N-1:0]    pend,
    input  wire [N*LW-1:0] prio,
    output reg             any,
    output reg  [IW-1:0]   idx,
    output reg  [LW-1:0]   lvl
);
    integer i;

    // Scan all sources; only a strictly higher level replaces the best
    always @* begin
        any = 1'b0;
        idx = {IW{1'b0}};
        lvl = {LW{1'b0}};
        for (i = 0; i < N; i = i + 1) begin
            if (pend[i] && (!any || prio[i*LW +: LW] > lvl)) begin
                any = 1'b1;
                idx = i[IW-1:0];
                lvl = prio[i*LW +: LW];
            end
        end
    end
endmodule // ivt_arb

// ===== logic/ivt_top.v
// Interrupt vector and trap unit: request and enable flags, priority
// levels, trap flags and selection of the vector presented to the core.
// Assumes a core that acknowledges the presented vector with a pulse
// and signals the end of a trap service; register port on clk.
//
// Behaviour
// - Channels 6-15, timers 0/1 get own numbers
// - Channels 16-31 and shared sources mapped
// - Traps act immediately, no mask applies
// - Trap branches to its own vector; the six class B traps share trap number 0x0a
// - Each trap sets its own flag bit
// - Trap pre-empts unless equal or higher trap running
// - No interrupt during trap service
// - Sixteen levels; only strictly higher pre-empts
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "ivt_defines.vh"
module ivt_top (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire [`IVT_NSRC-1:0]    src_evt,
    input  wire [`IVT_NTRAP-1:0]   hw_trap,
    input  wire [3:0]              cpu_level,
    input  wire                    vec_ack,
    input  wire                    trap_done,
    input  wire [7:0]              reg_addr,
    input  wire [15:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output wire [15:0]             reg_rdata,
    output wire                    vec_req,
    output wire [8:0]              vec_addr,
    output wire [6:0]              vec_tnum,
    output wire [3:0]              vec_lvl,
    output wire                    vec_trap,
    output wire                    irq
);
    localparam NS = `IVT_NSRC;
    localparam NT = `IVT_NTRAP;

    reg                 rst_s1_r;
    reg                 rst_s2_r;
    wire                rst_i_n;
    reg  [63:0]         en_r;
    reg  [3:0]          prio_r [0:NS-1];
    reg  [`IVT_NEV-1:0] msk_r;
    reg  [2:0]          trap_lvl_r;
    reg                 vec_req_r;
    reg  [6:0]          vec_tnum_r;
    reg  [3:0]          vec_lvl_r;
    reg                 vec_trap_r;
    reg  [5:0]          vec_src_r;
    reg  [2:0]          vec_rank_r;
    reg  [NT-1:0]       vec_tclr_r;
    reg  [15:0]         rdata_r;
    reg  [15:0]         rdata_nxt;
    reg                 vec_req_nxt;
    reg  [6:0]          vec_tnum_nxt;
    reg  [3:0]          vec_lvl_nxt;
    reg                 vec_trap_nxt;
    reg  [2:0]          t_rank;
    reg  [6:0]          t_tnum;
    reg  [NT-1:0]       t_clr;
    wire [NS-1:0]       req_flags;
    wire [NT-1:0]       tfr_flags;
    wire [NT-1:0]       tpend;
    wire [`IVT_NEV-1:0] sts_flags;
    wire [NS*4-1:0]     prio_flat;
    wire                arb_any;
    wire [5:0]          arb_idx;
    wire [3:0]          arb_lvl;
    wire                t_ok;
    wire                int_ok;
    wire                wr_req;
    wire                wr_en;
    wire                wr_prio;
    wire [63:0]         req_sw_clr;
    wire [NS-1:0]       ack_clr;
    wire                ack_trap;
    wire                ack_int;
    wire [`IVT_NEV-1:0] ev_set;
    wire [5:0]          word_base;
    wire [63:0]         req_pad;
    wire [63:0]         en_pad;

    // Reset release through two flip-flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_i_n = rst_s2_r;

    // Register write decode
    assign word_base = {reg_addr[1:0], 4'h0};
    assign wr_req  = reg_wr && (reg_addr[7:2] == `IVT_A_REQ >> 2);
    assign wr_en   = reg_wr && (reg_addr[7:2] == `IVT_A_EN >> 2);
    assign wr_prio = reg_wr && (reg_addr[7:6] == `IVT_A_PRIO >> 6)
                     && (reg_addr[5:0] < NS);
    assign req_sw_clr = wr_req ? ({48'h0, reg_wdata} << word_base) : 64'h0;

    // Acknowledge of the vector shown in the same cycle
    assign ack_trap = vec_ack && vec_req_r && vec_trap_r;
    assign ack_int  = vec_ack && vec_req_r && !vec_trap_r;
    assign ack_clr  = ack_int ? ({{(NS-1){1'b0}}, 1'b1} << vec_src_r)
                              : {NS{1'b0}};

    // Request flags: set by source events, cleared on service or by a one
    ivt_flag #(
        .W     (NS)
    ) u_req (
        .clk   (clk),
        .rst_n (rst_i_n),
        .set   (src_evt),
        .clr   (req_sw_clr[NS-1:0] | ack_clr),
        .flag  (req_flags)
    );

    // Trap flag register: one bit per trap, write one to clear
    ivt_flag #(
        .W     (NT)
    ) u_tfr (
        .clk   (clk),
        .rst_n (rst_i_n),
        .set   (hw_trap),
        .clr   ((reg_wr && reg_addr == `IVT_A_TFR) ? reg_wdata[NT-1:0]
                                                   : {NT{1'b0}}),
        .flag  (tfr_flags)
    );

    // Traps waiting to be taken by the core
    ivt_flag #(
        .W     (NT)
    ) u_tpend (
        .clk   (clk),
        .rst_n (rst_i_n),
        .set   (hw_trap),
        .clr   (ack_trap ? vec_tclr_r : {NT{1'b0}}), // Only the shown trap; all class B bits for class B
        .flag  (tpend)
    );

    // Event status, cleared by a read of the status register
    assign ev_set[`IVT_EV_FLAG] = |hw_trap;
    assign ev_set[`IVT_EV_TRAP] = ack_trap;
    assign ev_set[`IVT_EV_INT]  = ack_int;
    ivt_flag #(
        .W     (`IVT_NEV)
    ) u_sts (
        .clk   (clk),
        .rst_n (rst_i_n),
        .set   (ev_set),
        .clr   ({`IVT_NEV{reg_rd && reg_addr == `IVT_A_STS}}),
        .flag  (sts_flags)
    );
    assign irq = |(sts_flags & msk_r);

    // Software state: enables, priority levels, event mask
    integer k;
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            en_r  <= `IVT_RST_EN;
            msk_r <= `IVT_RST_MSK;
            for (k = 0; k < NS; k = k + 1)
                prio_r[k] <= `IVT_RST_PRIO;
        end else begin
            if (wr_en)
                en_r[word_base +: 16] <= reg_wdata;
            if (wr_prio)
                prio_r[reg_addr[5:0]] <= reg_wdata[3:0];
            if (reg_wr && reg_addr == `IVT_A_MSK)
                msk_r <= reg_wdata[`IVT_NEV-1:0];
        end
    end

    // Flatten priority fields for the arbiter
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1) begin : g_prio
            assign prio_flat[g*4 +: 4] = prio_r[g];
        end
    endgenerate

    // Highest pending enabled source
    ivt_arb #(
        .N    (NS),
        .IW   (6),
        .LW   (4)
    ) u_arb (
        .pend (req_flags & en_r[NS-1:0]),
        .prio (prio_flat),
        .any  (arb_any),
        .idx  (arb_idx),
        .lvl  (arb_lvl)
    );

    // Trap ranking: NMI, stack overflow, stack underflow, then class B
    always @* begin
        t_rank = `IVT_RK_NONE;
        t_tnum = 7'h00;
        t_clr  = {NT{1'b0}};
        if (tpend[0]) begin
            t_rank = `IVT_RK_NMI;
            t_tnum = `IVT_TN_NMI;
            t_clr  = 9'h001;
        end else if (tpend[1]) begin
            t_rank = `IVT_RK_STKOF;
            t_tnum = `IVT_TN_STKOF;
            t_clr  = 9'h002;
        end else if (tpend[2]) begin
            t_rank = `IVT_RK_STKUF;
            t_tnum = `IVT_TN_STKUF;
            t_clr  = 9'h004;
        end else if (|(tpend & `IVT_CLSB_MASK)) begin
            t_rank = `IVT_RK_CLSB;
            t_tnum = `IVT_TN_CLSB;
            t_clr  = `IVT_CLSB_MASK;
        end
    end

    // Trap needs no enable or level; waits only for a trap of equal or higher rank
    assign t_ok = (t_rank > trap_lvl_r);
    // Interrupts only outside traps and strictly above the core level
    assign int_ok = arb_any && (arb_lvl > cpu_level)
                    && (trap_lvl_r == `IVT_RK_NONE);

    // Choose what the core sees next; an acknowledge withdraws it
    always @* begin
        vec_req_nxt  = (t_ok || int_ok) && !vec_ack;
        vec_trap_nxt = 1'b0;
        vec_tnum_nxt = 7'h00;
        vec_lvl_nxt  = 4'h0;
        if (t_ok) begin
            vec_trap_nxt = 1'b1;
            vec_tnum_nxt = t_tnum;
            vec_lvl_nxt  = `IVT_LVL_TRAP;
        end else if (int_ok) begin
            vec_tnum_nxt = `IVT_TN_BASE + {1'b0, arb_idx};
            vec_lvl_nxt  = arb_lvl;
        end
    end

    // Presented vector and running trap rank
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            vec_req_r  <= 1'b0;
            vec_trap_r <= 1'b0;
            vec_tnum_r <= 7'h00;
            vec_lvl_r  <= 4'h0;
            vec_src_r  <= 6'h00;
            vec_rank_r <= `IVT_RK_NONE;
            vec_tclr_r <= {NT{1'b0}};
            trap_lvl_r <= `IVT_RK_NONE;
        end else begin
            vec_req_r  <= vec_req_nxt;
            vec_trap_r <= vec_trap_nxt;
            vec_tnum_r <= vec_tnum_nxt;
            vec_lvl_r  <= vec_lvl_nxt;
            vec_src_r  <= arb_idx;
            vec_rank_r <= t_rank;
            vec_tclr_r <= t_clr;
            if (ack_trap)
                trap_lvl_r <= vec_rank_r;
            else if (trap_done)
                trap_lvl_r <= `IVT_RK_NONE;
        end
    end

    assign vec_req  = vec_req_r;
    assign vec_trap = vec_trap_r;
    assign vec_tnum = vec_tnum_r;
    assign vec_lvl  = vec_lvl_r;
    assign vec_addr = {vec_tnum_r, 2'b00};

    // Read data, valid in the cycle after the read strobe
    always @* begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            if (reg_addr[7:2] == `IVT_A_REQ >> 2)
                rdata_nxt = req_pad[word_base +: 16];
            else if (reg_addr[7:2] == `IVT_A_EN >> 2)
                rdata_nxt = en_pad[word_base +: 16];
            else if (reg_addr == `IVT_A_TFR)
                rdata_nxt = {7'h00, tfr_flags};
            else if (reg_addr == `IVT_A_STS)
                rdata_nxt = {13'h0000, sts_flags};
            else if (reg_addr == `IVT_A_MSK)
                rdata_nxt = {13'h0000, msk_r};
            else if (reg_addr == `IVT_A_CORE)
                rdata_nxt = {vec_req_r, vec_trap_r, 3'h0, trap_lvl_r,
                             1'b0, vec_tnum_r};
            else if (wr_prio_rd(reg_addr))
                rdata_nxt = {12'h000, prio_r[reg_addr[5:0]]};
        end
    end

    // Flags and enables padded to four words; unused bits read as zero
    assign req_pad = {{(64-NS){1'b0}}, req_flags};
    assign en_pad  = {{(64-NS){1'b0}}, en_r[NS-1:0]};

    // Priority window holds one field per source
    function wr_prio_rd;
        input [7:0] a;
        begin
            wr_prio_rd = (a[7:6] == `IVT_A_PRIO >> 6) && (a[5:0] < NS);
        end
    endfunction

    // Read data register
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n)
            rdata_r <= 16'h0000;
        else
            rdata_r <= rdata_nxt;
    end
    assign reg_rdata = rdata_r;
endmodule // ivt_top

// ===== test/ivt_monitor.sv
// Checker of the vector and trap unit, watching its ports only.
// Assumes one clock and the asynchronous active-low reset of the unit.
`timescale 1ns/1ns
module ivt_monitor (
    input wire        clk,
    input wire        rst_n,
    input wire [8:0]  hw_trap,
    input wire [3:0]  cpu_level,
    input wire        vec_ack,
    input wire        trap_done,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        vec_req,
    input wire [8:0]  vec_addr,
    input wire [6:0]  vec_tnum,
    input wire [3:0]  vec_lvl,
    input wire        vec_trap
);
    reg in_trap_r;
    reg nmi_run_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Marks a trap service taken by the core until it reports the end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_trap_r <= 1'b0;
            nmi_run_r <= 1'b0;
        end else if (vec_ack && vec_req && vec_trap) begin
            in_trap_r <= 1'b1;
            nmi_run_r <= (vec_tnum == 7'h02);
        end else if (trap_done) begin
            in_trap_r <= 1'b0;
            nmi_run_r <= 1'b0;
        end
    end

    AST_ADDR: assert property (vec_req |-> vec_addr == {vec_tnum, 2'b00})
        else $error("vector address is not trap number times four");
    AST_SRC: assert property (vec_req && !vec_trap |->
        vec_tnum >= 7'h16 && vec_tnum <= 7'h47)
        else $error("source trap number out of range");
    AST_TLVL: assert property (vec_req && vec_trap |-> vec_lvl == 4'hf)
        else $error("trap offered below top level");
    AST_TNUM: assert property (vec_req && vec_trap |->
        vec_tnum inside {7'h02, 7'h04, 7'h06, 7'h0a})
        else $error("trap offered with a foreign number");
    AST_NMI: assert property (!nmi_run_r && hw_trap[0] && !vec_ack
        ##1 !vec_ack |=> vec_req && vec_trap && vec_tnum == 7'h02)
        else $error("non-maskable trap not offered in two cycles");
    AST_NOINT: assert property (in_trap_r && vec_req |-> vec_trap)
        else $error("interrupt offered during trap service");
    AST_LVL: assert property (vec_req && !vec_trap && $stable(cpu_level)
        |-> vec_lvl > cpu_level)
        else $error("interrupt offered at or below core level");
    AST_DROP: assert property (vec_ack && vec_req |=> !vec_req)
        else $error("vector still offered after acknowledge");
    AST_RDQ: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data outside read answer");

    // Main scenarios reached
    C_TRAP: cover property (vec_req && vec_trap && vec_ack);
    C_INT: cover property (vec_req && !vec_trap && vec_ack);
    C_DONE: cover property (in_trap_r && trap_done);
endmodule // ivt_monitor

bind ivt_top ivt_monitor u_ivt_monitor (
    .clk(clk), .rst_n(rst_n), .hw_trap(hw_trap), .cpu_level(cpu_level),
    .vec_ack(vec_ack), .trap_done(trap_done), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vec_req(vec_req), .vec_addr(vec_addr),
    .vec_tnum(vec_tnum), .vec_lvl(vec_lvl), .vec_trap(vec_trap)
);

// ===== test/ivt_core_model.sv
// Core model: acknowledges offered vectors after a delay, ends traps.
// Assumes the vector port of the unit on the same clock.
`timescale 1ns/1ns
module ivt_core_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       hold_trap,
    input  wire [1:0] ack_dly,
    input  wire       vec_req,
    input  wire       vec_trap,
    input  wire [6:0] vec_tnum,
    input  wire [8:0] vec_addr,
    output reg        vec_ack,
    output reg        trap_done,
    output reg  [7:0] ack_cnt,
    output reg  [8:0] last_addr,
    output reg  [6:0] last_tnum
);
    reg [1:0] wait_r;
    reg       busy_r;

    // Ack only while offered, record it, close a trap once released
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_ack <= 1'b0;
            trap_done <= 1'b0;
            ack_cnt <= 8'h0;
            last_addr <= 9'h0;
            last_tnum <= 7'h0;
            wait_r <= 2'h0;
            busy_r <= 1'b0;
        end else begin
            vec_ack <= vec_req && !vec_ack && wait_r >= ack_dly;
            wait_r <= (vec_req && !vec_ack) ? wait_r + 2'h1 : 2'h0;
            trap_done <= busy_r && !hold_trap && !trap_done;
            if (trap_done)
                busy_r <= 1'b0;
            if (vec_ack && vec_req) begin
                ack_cnt <= ack_cnt + 8'h1;
                last_addr <= vec_addr;
                last_tnum <= vec_tnum;
                if (vec_trap)
                    busy_r <= 1'b1;
            end
        end
    end
endmodule // ivt_core_model

// ===== test/ivt_top_tb.sv
// Self-checking bench of the vector and trap unit with a core model.
// Assumes a 20 MHz clock and the one-cycle register read answer.
`timescale 1ns/1ns
module ivt_top_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [49:0] src_evt = 50'h0;
    reg  [8:0]  hw_trap = 9'h0;
    reg  [3:0]  cpu_level = 4'h0;
    reg  [7:0]  reg_addr = 8'h0;
    reg  [15:0] reg_wdata = 16'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         hold_trap = 1'b0;
    reg  [1:0]  ack_dly = 2'h0;
    wire [15:0] reg_rdata;
    wire        vec_req, vec_trap, vec_ack, trap_done, irq;
    wire [8:0]  vec_addr, last_addr;
    wire [6:0]  vec_tnum, last_tnum;
    wire [3:0]  vec_lvl;
    wire [7:0]  ack_cnt;
    integer     seed = 32'hac16;
    integer     error_cnt = 0;
    integer     checks = 0;
    integer     i, k;
    reg  [5:0]  s;
    reg  [7:0]  n;
    reg  [59:0] corners;

    ivt_top u_ivt_top (.clk(clk), .rst_n(rst_n), .src_evt(src_evt),
        .hw_trap(hw_trap), .cpu_level(cpu_level), .vec_ack(vec_ack),
        .trap_done(trap_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .vec_req(vec_req), .vec_addr(vec_addr), .vec_tnum(vec_tnum),
        .vec_lvl(vec_lvl), .vec_trap(vec_trap), .irq(irq));
    ivt_core_model u_ivt_core_model (.clk(clk), .rst_n(rst_n),
        .hold_trap(hold_trap), .ack_dly(ack_dly), .vec_req(vec_req),
        .vec_trap(vec_trap), .vec_tnum(vec_tnum), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .trap_done(trap_done), .ack_cnt(ack_cnt),
        .last_addr(last_addr), .last_tnum(last_tnum));

    // Clock of 50 ns period
    always #25 clk = ~clk;

    // Trap number expected for a source index
    function [6:0] exp_tnum(input [5:0] idx);
        exp_tnum = 7'h16 + {1'b0, idx};
    endfunction

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task wr(input [7:0] a, input [15:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask

    task rd(input [7:0] a, input [15:0] exp);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata, exp);
            @(posedge clk);
        end
    endtask

    task pulse(input [49:0] se, input [8:0] t);
        begin
            src_evt <= se;
            hw_trap <= t;
            @(posedge clk);
            src_evt <= 50'h0;
            hw_trap <= 9'h0;
            @(posedge clk);
        end
    endtask

    task wait_ack(input [7:0] cnt);
        begin
            k = 0;
            while (ack_cnt !== cnt && k < 40) begin
                @(posedge clk);
                #1;
                k = k + 1;
            end
            chk({8'h0, ack_cnt}, {8'h0, cnt});
            @(posedge clk);
        end
    endtask

    // Cuts a hang short
    initial begin
        #(50 * 20000);
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        corners = {6'd49, 6'd46, 6'd45, 6'd42, 6'd38, 6'd26, 6'd11, 6'd10,
                   6'd9, 6'd0};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 14; i = i + 1) begin
            s = (i < 10) ? corners[i*6 +: 6] : $unsigned($random(seed)) % 50;
            ack_dly <= $random(seed);
            wr(8'h04 + s[5:4], 16'h1 << s[3:0]);
            wr(8'h40 + s, 16'h1 + $unsigned($random(seed)) % 15);
            n = ack_cnt + 8'h1;
            pulse(50'h1 << s, 9'h0);
            wait_ack(n);
            chk(last_tnum, exp_tnum(s));
            chk(last_addr, {exp_tnum(s), 2'b00});
            rd(8'h00 + s[5:4], 16'h0);
            wr(8'h04 + s[5:4], 16'h0);
        end
        $display("test source mapping done");
        wr(8'h04, 16'h00a8);
        wr(8'h05, 16'h0010);
        wr(8'h43, 16'h0006);
        wr(8'h45, 16'h0003);
        wr(8'h47, 16'h0009);
        wr(8'h54, 16'h0009);
        cpu_level <= 4'h9;
        n = ack_cnt;
        pulse(50'h1000a8, 9'h0);
        repeat (10) @(posedge clk);
        chk({8'h0, ack_cnt}, {8'h0, n});
        cpu_level <= 4'h0;
        wait_ack(n + 8'h1);
        chk(last_tnum, exp_tnum(6'd7));
        wait_ack(n + 8'h2);
        chk(last_tnum, exp_tnum(6'd20));
        wait_ack(n + 8'h3);
        chk(last_tnum, exp_tnum(6'd3));
        wait_ack(n + 8'h4);
        chk(last_tnum, exp_tnum(6'd5));
        rd(8'h45, 16'h0003);
        rd(8'h05, 16'h0010);
        $display("test priority levels done");
        hold_trap <= 1'b1;
        wr(8'h04, 16'h0002);
        wr(8'h41, 16'h0004);
        wr(8'h0a, 16'h0007);
        n = ack_cnt;
        pulse(50'h0, 9'h004);
        wait_ack(n + 8'h1);
        chk(last_tnum, 16'h06);
        chk(last_addr, 16'h018);
        pulse(50'h2, 9'h0);
        repeat (10) @(posedge clk);
        chk({8'h0, ack_cnt}, {8'h0, n + 8'h1});
        pulse(50'h0, 9'h001);
        wait_ack(n + 8'h2);
        chk(last_tnum, 16'h02);
        pulse(50'h0, 9'h002);
        repeat (10) @(posedge clk);
        chk({8'h0, ack_cnt}, {8'h0, n + 8'h2});
        rd(8'h0b, 16'h0400);
        hold_trap <= 1'b0;
        wait_ack(n + 8'h3);
        chk(last_addr, 16'h010);
        wait_ack(n + 8'h4);
        chk(last_tnum, exp_tnum(6'd1));
        pulse(50'h0, 9'h100);
        wait_ack(n + 8'h5);
        chk(last_addr, 16'h028);
        #1;
        chk(irq, 1'b1);
        @(posedge clk);
        rd(8'h08, 16'h0107);
        wr(8'h08, 16'h01ff);
        rd(8'h08, 16'h0000);
        rd(8'h09, 16'h0007);
        rd(8'h09, 16'h0000);
        #1;
        chk(irq, 1'b0);
        @(posedge clk);
        wr(8'h0a, 16'h0004);
        pulse(50'h0, 9'h008);
        wait_ack(n + 8'h6);
        #1;
        chk(irq, 1'b0);
        @(posedge clk);
        rd(8'h09, 16'h0003);
        rd(8'h20, 16'h0000);
        $display("test hardware traps done");
        repeat (5) @(posedge clk);
        tally_and_finish;
    end
endmodule // ivt_top_tb
